// *** dpr_bank.v ***
`timescale 1ns/1ps
`default_nettype none
`include "dpr_regs.vh"
module dpr_bank #(
  parameter QUEUE_AW = 4
) (
  // clock and reset
  input wire clk_sys,
  input wire reset_n,
  // host word port
  input wire [7:0] host_addr,
  input wire host_rd_stb,
  input wire host_wr_stb,
  input wire [15:0] host_wdata,
  output reg [15:0] host_rdata,
  output reg host_rvalid,
  // firmware event push
  input wire evt_push,
  input wire [14:0] evt_code,
  input wire [15:0] evt_param,
  output wire evt_ready,
  // live status from the chip
  input wire [15:0] sys_fault_in,
  input wire [15:0] clk_status_in,
  input wire [31:0] boot_sense_in,
  input wire [3:0] reset_cause_in,
  input wire chip_ready_in,
  input wire [1:0] fw_mbox_clr,
  // configuration outputs
  output reg [15:0] page_offset_out,
  output reg [1:0] mbox_flag_out,
  output reg [31:0] checksum_out,
  output reg [31:0] base_addr_out,
  output reg [15:0] pcm_clock_b_select_out,
  output reg [15:0] pcm_clock_a_select_out,
  output reg [15:0] mclk_cfg_out,
  output reg [15:0] sys_mask_out,
  output reg [31:0] entry_addr_out,
  output reg irq_pending
);
  // ****************************
  // address decode helper
  // ****************************
  // shared by read and write paths
  function hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  // ****************************
  // state
  // ****************************
  reg [15:0] irq_param_q; // parameter of last read
  reg [15:0] irq_param_d;
  reg [14:0] sys_pend_q; // unmasked transitions
  reg [14:0] sys_pend_d;
  reg [14:0] fault_prev_q; // last sampled status
  reg [15:0] ind_word; // indication as it reads now
  reg [15:0] rdata_d; // read mux result
  reg q_pop; // drain one queued event

  // queue outputs
  wire q_valid;
  wire [30:0] q_dout;

  // decoded strobes
  wire rd_ind = host_rd_stb & hit(host_addr, `DPR_OFS_IRQ_IND);
  wire wr_any = host_wr_stb;

  // fault bits that moved this cycle
  wire [14:0] fault_edge;
  // only those not masked may raise [RULE6]
  wire [14:0] fault_new;

  // ****************************
  // fault transition detect
  // ****************************
  // one detector per status bit 0 to 14 (bit 15 has none); the history
  // resets low, so a bit already high out of
  // reset is reported once as a transition
  genvar gi;
  generate
    for (gi = 0; gi < 15; gi = gi + 1)
    begin : g_fault
      // moved since the last edge [RULE5]
      assign fault_edge[gi] = sys_fault_in[gi] ^ fault_prev_q[gi];
      // masked moves are dropped, not remembered [RULE6]
      assign fault_new[gi] = fault_edge[gi] & ~sys_mask_out[gi];
    end
  endgenerate

  // ****************************
  // event queue
  // ****************************
  // code in the top 15 bits, parameter below
  dpr_evq #(
    .WIDTH(31),
    .AW(QUEUE_AW)
  ) u_evq (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .push(evt_push),
    .din({evt_code, evt_param}),
    .ready(evt_ready),
    .pop(q_pop),
    .valid(q_valid),
    .dout(q_dout)
  );

  // ****************************
  // indication word
  // ****************************
  // system faults win over the queue so a
  // fault is never starved by chatty events
  always @*
  begin
    ind_word = `DPR_RST_WORD;
    if (|sys_pend_q)
    begin
      // source bit set, field is a bit map [RULE4] [RULE5]
      ind_word[`DPR_BIT_IRQ_SRC] = 1'b1;
      ind_word[14:0] = sys_pend_q;
    end
    else if (q_valid)
    begin
      // source bit clear, field is the code [RULE4] [RULE7]
      ind_word[`DPR_BIT_IRQ_SRC] = 1'b0;
      ind_word[14:0] = q_dout[30:16];
    end
    // otherwise the word stays all zero [RULE1];
    // a queued code of zero would look the same,
    // so firmware must never push code zero
  end

  // ****************************
  // clear on read and parameter load
  // ****************************
  always @*
  begin
    irq_param_d = irq_param_q;
    q_pop = 1'b0;
    // new transitions always merge in, so a
    // fault arriving on the clearing read wins
    sys_pend_d = sys_pend_q | fault_new;
    if (rd_ind)
    begin
      if (|sys_pend_q)
      begin
        // drop what was reported, keep new ones [RULE2]
        sys_pend_d = (sys_pend_q & ~ind_word[14:0]) | fault_new;
        // status copy as it stood at the read [RULE13]
        irq_param_d = sys_fault_in;
      end
      else if (q_valid)
      begin
        // retire the head event [RULE2] [RULE15]
        q_pop = 1'b1;
        irq_param_d = q_dout[15:0];
      end
      else
      begin
        // nothing pending, parameter reads zero
        irq_param_d = `DPR_RST_WORD;
      end
    end
  end

  // ****************************
  // interrupt state registers
  // ****************************
  // all interrupt state runs on the one clock
  always @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      // nothing pending, no stale parameter
      irq_param_q <= `DPR_RST_WORD;
      sys_pend_q <= 15'h0000;
      fault_prev_q <= 15'h0000;
      irq_pending <= 1'b0;
    end
    else
    begin
      irq_param_q <= irq_param_d;
      sys_pend_q <= sys_pend_d;
      // history for the edge detectors
      fault_prev_q <= sys_fault_in[14:0];
      // one cycle behind the pending state
      irq_pending <= (|sys_pend_q) | q_valid;
    end
  end

  // ****************************
  // read mux
  // ****************************
  // reserved mailbox and reset cause bits read zero; the
  // host is expected to write them as zero [RULE8]
  always @*
  begin
    rdata_d = `DPR_RST_WORD;
    case (host_addr)
      `DPR_OFS_IRQ_IND:
        rdata_d = ind_word;
      `DPR_OFS_IRQ_PARAM:
        // pure read, no side effect [RULE3] [RULE14]
        rdata_d = irq_param_q;
      `DPR_OFS_PAGE_OFS:
        rdata_d = page_offset_out;
      `DPR_OFS_MBOX:
        rdata_d = {14'h0000, mbox_flag_out};
      `DPR_OFS_CHK_HI:
        rdata_d = checksum_out[31:16]; // [RULE12]
      `DPR_OFS_CHK_LO:
        rdata_d = checksum_out[15:0]; // [RULE12]
      `DPR_OFS_BASE_HI:
        rdata_d = base_addr_out[31:16];
      `DPR_OFS_BASE_LO:
        // busy bit high until internal reset ends
        rdata_d = {base_addr_out[15:1], ~chip_ready_in};
      `DPR_OFS_PCLKB:
        rdata_d = pcm_clock_b_select_out;
      `DPR_OFS_PCLKA:
        rdata_d = pcm_clock_a_select_out;
      `DPR_OFS_CLK_STAT:
        rdata_d = clk_status_in;
      `DPR_OFS_MCLK_CFG:
        rdata_d = mclk_cfg_out;
      `DPR_OFS_SYS_STAT:
        rdata_d = sys_fault_in;
      `DPR_OFS_SYS_MASK:
        rdata_d = sys_mask_out;
      `DPR_OFS_BSENSE_HI:
        rdata_d = boot_sense_in[31:16];
      `DPR_OFS_BSENSE_LO:
        rdata_d = boot_sense_in[15:0];
      `DPR_OFS_RST_CAUSE:
        // cause code in the low nibble [RULE9]
        rdata_d = {12'h000, reset_cause_in};
      `DPR_OFS_ENTRY_HI:
        rdata_d = entry_addr_out[31:16];
      `DPR_OFS_ENTRY_LO:
        rdata_d = entry_addr_out[15:0];
      default:
        // unmapped offsets read zero
        rdata_d = `DPR_RST_WORD;
    endcase
  end

  // ****************************
  // registered read answer
  // ****************************
  // answer one cycle after the strobe; data
  // holds until the next read so a host that
  // samples late still sees the same word
  always @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      host_rdata <= `DPR_RST_WORD;
      host_rvalid <= 1'b0;
    end
    else
    begin
      // one pulse per read strobe
      host_rvalid <= host_rd_stb;
      if (host_rd_stb)
        host_rdata <= rdata_d;
    end
  end

  // ****************************
  // mailbox flags
  // ****************************
  // host can only hand a box over (write 1);
  // firmware hands it back by its clear strobe.
  // a host set in the same cycle wins.
  always @(posedge clk_sys)
  begin
    if (!reset_n)
      // host owns both boxes out of reset
      mbox_flag_out <= 2'b00;
    else if (wr_any & hit(host_addr, `DPR_OFS_MBOX))
      mbox_flag_out <= (mbox_flag_out & ~fw_mbox_clr) |
        host_wdata[`DPR_BIT_RSP_FLAG:`DPR_BIT_CMD_FLAG];
    else
      mbox_flag_out <= mbox_flag_out & ~fw_mbox_clr;
  end

  // ****************************
  // plain writable words
  // ****************************
  // entry words are plain storage; ordering
  // against the software flags is the host's job
  always @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      page_offset_out <= `DPR_RST_WORD;
      checksum_out <= {`DPR_RST_WORD, `DPR_RST_WORD};
      // low bit is shadowed by the busy flag on reads
      base_addr_out <= {`DPR_RST_WORD, `DPR_RST_BASE_LO};
      // autodetect set on both selects [RULE11]
      pcm_clock_b_select_out <= `DPR_RST_PCLK_SEL;
      pcm_clock_a_select_out <= `DPR_RST_PCLK_SEL;
      mclk_cfg_out <= `DPR_RST_WORD;
      sys_mask_out <= `DPR_RST_WORD;
      entry_addr_out <= {`DPR_RST_WORD, `DPR_RST_WORD};
    end
    else if (wr_any)
    begin
      case (host_addr)
        `DPR_OFS_PAGE_OFS:
          page_offset_out <= host_wdata;
        `DPR_OFS_CHK_HI:
          checksum_out[31:16] <= host_wdata; // [RULE12]
        `DPR_OFS_CHK_LO:
          checksum_out[15:0] <= host_wdata; // [RULE12]
        `DPR_OFS_BASE_HI:
          base_addr_out[31:16] <= host_wdata;
        `DPR_OFS_BASE_LO:
          // busy bit is read only, not stored
          base_addr_out[15:1] <= host_wdata[15:1];
        `DPR_OFS_PCLKB:
          pcm_clock_b_select_out <= host_wdata;
        `DPR_OFS_PCLKA:
          pcm_clock_a_select_out <= host_wdata;
        `DPR_OFS_MCLK_CFG:
          mclk_cfg_out <= host_wdata;
        `DPR_OFS_SYS_MASK:
          // one masks a fault bit [RULE6]
          sys_mask_out <= host_wdata;
        `DPR_OFS_ENTRY_HI:
          entry_addr_out[31:16] <= host_wdata;
        `DPR_OFS_ENTRY_LO:
          entry_addr_out[15:0] <= host_wdata;
        default:
          // read only or unmapped: ignored
          page_offset_out <= page_offset_out;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** dpr_regs.vh ***
// Notes on behaviour
// [RULE1] no pending interrupt reads as zero word
// [RULE2] indication read clears it, loads parameter
// [RULE3] parameter sits right after the indication
// [RULE4] bit 15 selects queue or system source
// [RULE5] system field flags fault status transitions
// [RULE6] only unmasked fault transitions are reported
// [RULE7] source zero carries a queued event code
// [RULE8] reserved bits written zero, read unspecified
// [RULE9] reset cause four bits at 0x16
// [RULE10] host writes entry before software flags
// [RULE11] both pcm clock selects default autodetect
// [RULE12] boot checksum high at 0x04, low 0x05
// [RULE13] system parameter copies status at read
// [RULE14] parameter read leaves interrupt state alone
// [RULE15] queued events leave in arrival order
`ifndef DPR_REGS_VH
`define DPR_REGS_VH
// ****************************
// direct page word offsets
// ****************************
`define DPR_OFS_IRQ_IND 8'h00
`define DPR_OFS_IRQ_PARAM 8'h01
`define DPR_OFS_PAGE_OFS 8'h02
`define DPR_OFS_MBOX 8'h03
`define DPR_OFS_CHK_HI 8'h04
`define DPR_OFS_CHK_LO 8'h05
`define DPR_OFS_BASE_HI 8'h06
`define DPR_OFS_BASE_LO 8'h07
`define DPR_OFS_PCLKB 8'h08
`define DPR_OFS_PCLKA 8'h09
`define DPR_OFS_CLK_STAT 8'h0A
`define DPR_OFS_MCLK_CFG 8'h0B
`define DPR_OFS_SYS_STAT 8'h0C
`define DPR_OFS_SYS_MASK 8'h0D
`define DPR_OFS_BSENSE_HI 8'h14
`define DPR_OFS_BSENSE_LO 8'h15
`define DPR_OFS_RST_CAUSE 8'h16
`define DPR_OFS_ENTRY_HI 8'h18
`define DPR_OFS_ENTRY_LO 8'h19
// ****************************
// field positions
// ****************************
`define DPR_BIT_IRQ_SRC 15
`define DPR_BIT_CMD_FLAG 0
`define DPR_BIT_RSP_FLAG 1
`define DPR_BIT_BASE_BUSY 0
// ****************************
// reset values
// ****************************
`define DPR_RST_WORD 16'h0000
`define DPR_RST_PCLK_SEL 16'h0080
`define DPR_RST_BASE_LO 16'hFF00
`endif

// *** dpr_evq.v ***
`timescale 1ns/1ps
`default_nettype none
// ****************************
// event queue, first in first out
// ****************************
module dpr_evq #(
  parameter WIDTH = 31,
  parameter AW = 4
) (
  // clock and reset
  input wire clk_sys,
  input wire reset_n,
  // filling side
  input wire push,
  input wire [WIDTH-1:0] din,
  output wire ready,
  // draining side
  input wire pop,
  output wire valid,
  output wire [WIDTH-1:0] dout
);
  localparam [AW:0] DEPTH = {1'b1, {AW{1'b0}}}; // full level, sized to the counter
  reg [WIDTH-1:0] mem [0:DEPTH-1]; // entry store
  reg [AW-1:0] wr_q; // write pointer
  reg [AW-1:0] rd_q; // read pointer
  reg [AW:0] cnt_q; // fill level
  reg [AW:0] cnt_d;
  reg ready_q; // room left
  reg valid_q; // entry present
  wire do_push = push & ready_q;
  wire do_pop = pop & valid_q;
  assign ready = ready_q;
  assign valid = valid_q;
  assign dout = mem[rd_q];
  // next fill level
  always @*
  begin
    cnt_d = cnt_q;
    if (do_push & ~do_pop)
      cnt_d = cnt_q + 1'b1;
    else if (do_pop & ~do_push)
      cnt_d = cnt_q - 1'b1;
  end
  // pointers and flags, strict arrival order [RULE15]
  always @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
      ready_q <= 1'b0;
      valid_q <= 1'b0;
    end
    else
    begin
      if (do_push)
        wr_q <= wr_q + 1'b1;
      if (do_pop)
        rd_q <= rd_q + 1'b1;
      cnt_q <= cnt_d;
      ready_q <= (cnt_d != DEPTH);
      valid_q <= (cnt_d != {(AW+1){1'b0}});
    end
  end
  // storage has no reset; pointers guard it
  always @(posedge clk_sys)
  begin
    if (do_push)
      mem[wr_q] <= din;
  end
endmodule
`default_nettype wire

// *** dpr_bank_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************
// bank port checks
// ****************************
module dpr_bank_chk (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // host port
  input wire logic [7:0] host_addr,
  input wire logic host_rd_stb,
  input wire logic host_wr_stb,
  input wire logic [15:0] host_wdata,
  input wire logic [15:0] host_rdata,
  input wire logic host_rvalid,
  // status and configuration
  input wire logic [15:0] sys_fault_in,
  input wire logic [3:0] reset_cause_in,
  input wire logic [31:0] checksum_out,
  input wire logic [15:0] pcm_clock_b_select_out,
  input wire logic [15:0] pcm_clock_a_select_out,
  input wire logic [15:0] sys_mask_out
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // two parameter reads back to back
  sequence s_par2;
    host_rd_stb && host_addr == 8'h01 ##1 host_rd_stb && host_addr == 8'h01;
  endsequence
  property p_rd_ans;
    host_rd_stb |=> host_rvalid;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read strobe got no answer");
  property p_no_ans;
    !host_rd_stb |=> !host_rvalid;
  endproperty
  a_no_ans: assert property (p_no_ans) else $error("answer without read strobe");
  property p_cause;
    host_rd_stb && host_addr == 8'h16 |=> host_rdata[3:0] == $past(reset_cause_in);
  endproperty
  a_cause: assert property (p_cause) else $error("reset cause read wrong");
  property p_stat;
    host_rd_stb && host_addr == 8'h0C |=> host_rdata == $past(sys_fault_in);
  endproperty
  a_stat: assert property (p_stat) else $error("fault status read wrong");
  property p_pclk;
    $rose(reset_n) |-> pcm_clock_b_select_out == 16'h0080 && pcm_clock_a_select_out == 16'h0080;
  endproperty
  a_pclk: assert property (p_pclk) else $error("pcm clock select not autodetect");
  property p_par2;
    s_par2 |=> host_rdata == $past(host_rdata);
  endproperty
  a_par2: assert property (p_par2) else $error("parameter read changed state");
  property p_chk;
    host_wr_stb && host_addr == 8'h04 |=> checksum_out[31:16] == $past(host_wdata);
  endproperty
  a_chk: assert property (p_chk) else $error("checksum high word not stored");
  property p_mask;
    host_wr_stb && host_addr == 8'h0D |=> sys_mask_out == $past(host_wdata);
  endproperty
  a_mask: assert property (p_mask) else $error("fault mask not stored");
endmodule
bind dpr_bank dpr_bank_chk u_dpr_bank_chk (.clk_sys, .reset_n, .host_addr, .host_rd_stb, .host_wr_stb,
  .host_wdata, .host_rdata, .host_rvalid, .sys_fault_in, .reset_cause_in, .checksum_out,
  .pcm_clock_b_select_out, .pcm_clock_a_select_out, .sys_mask_out);
`default_nettype wire

// *** dpr_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************
// host side of the word port
// ****************************
module dpr_host_model (
  // clock
  input wire logic clk_sys,
  // requests to the bank
  output logic [7:0] host_addr,
  output logic host_rd_stb,
  output logic host_wr_stb,
  output logic [15:0] host_wdata,
  // answer from the bank
  input wire logic [15:0] host_rdata,
  input wire logic host_rvalid
);
  // idle bus from time zero
  initial
  begin
    host_addr = 8'h00;
    host_rd_stb = 1'b0;
    host_wr_stb = 1'b0;
    host_wdata = 16'h0000;
  end
  // one word write; released data inverted so stale values never look valid
  task wr(input logic [7:0] a, input logic [15:0] d);
    host_wr_stb = 1'b1;
    host_addr = a;
    host_wdata = d;
    @(negedge clk_sys);
    host_wr_stb = 1'b0;
    host_wdata = ~d;
    @(negedge clk_sys);
  endtask
  // one word read, answer taken a cycle after the strobe
  task rd(input logic [7:0] a, output logic [15:0] d);
    host_rd_stb = 1'b1;
    host_addr = a;
    @(negedge clk_sys);
    d = host_rdata;
    host_rd_stb = 1'b0;
    @(negedge clk_sys);
  endtask
  // two-word read, strobe held high across both words
  task rd2(input logic [7:0] a, input logic [7:0] step, output logic [15:0] d0, output logic [15:0] d1);
    host_rd_stb = 1'b1;
    host_addr = a;
    @(negedge clk_sys);
    d0 = host_rdata;
    host_addr = a + step;
    @(negedge clk_sys);
    d1 = host_rdata;
    host_rd_stb = 1'b0;
    @(negedge clk_sys);
  endtask
  // launch: entry address high word then low word; no software flags written
  task launch(input logic [31:0] entry);
    wr(8'h18, entry[31:16]);
    wr(8'h19, entry[15:0]);
  endtask
endmodule
`default_nettype wire

// *** direct_page_register_bank_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module direct_page_register_bank_test;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] host_addr;
  logic host_rd_stb, host_wr_stb, host_rvalid, evt_push, evt_ready, irq_pending;
  logic [15:0] page_offset_out, mclk_cfg_out;
  logic [1:0] mbox_flag_out;
  logic [15:0] host_wdata, host_rdata, evt_param, sys_fault_in, sys_mask_out, pcm_clock_b_select_out, pcm_clock_a_select_out;
  logic [14:0] evt_code;
  logic [3:0] reset_cause_in;
  logic [31:0] checksum_out, entry_addr_out, base_addr_out;
  logic [15:0] d0, d1;
  int mismatches = 0;
  int comparisons = 0;
  // ****************************
  // clock, stimulus defaults, units
  // ****************************
  always #5 clk_sys = ~clk_sys;
  initial
  begin
    evt_push = 1'b0;
    evt_code = 15'h0000;
    evt_param = 16'h0000;
    sys_fault_in = 16'h0000;
    reset_cause_in = 4'hA;
  end
  dpr_host_model u_dpr_host_model (.clk_sys(clk_sys), .host_addr(host_addr), .host_rd_stb(host_rd_stb),
    .host_wr_stb(host_wr_stb), .host_wdata(host_wdata), .host_rdata(host_rdata), .host_rvalid(host_rvalid));
  dpr_bank u_dpr_bank (.clk_sys(clk_sys), .reset_n(reset_n), .host_addr(host_addr), .host_rd_stb(host_rd_stb),
    .host_wr_stb(host_wr_stb), .host_wdata(host_wdata), .host_rdata(host_rdata), .host_rvalid(host_rvalid),
    .evt_push(evt_push), .evt_code(evt_code), .evt_param(evt_param), .evt_ready(evt_ready),
    .sys_fault_in(sys_fault_in), .clk_status_in(16'h0000), .boot_sense_in(32'h00000000),
    .reset_cause_in(reset_cause_in), .chip_ready_in(1'b1), .fw_mbox_clr(2'h0),
    .page_offset_out(page_offset_out), .mbox_flag_out(mbox_flag_out), .checksum_out(checksum_out),
    .base_addr_out(base_addr_out), .pcm_clock_b_select_out(pcm_clock_b_select_out), .pcm_clock_a_select_out(pcm_clock_a_select_out),
    .mclk_cfg_out(mclk_cfg_out), .sys_mask_out(sys_mask_out), .entry_addr_out(entry_addr_out),
    .irq_pending(irq_pending));
  // ****************************
  // shared compare and closing
  // ****************************
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ****************************
  // scenarios
  // ****************************
  // reset values, empty indication, reset cause, unmapped hole
  task t_reset;
    u_dpr_host_model.rd(8'h08, d0);
    chk(d0, 16'h0080);
    u_dpr_host_model.rd(8'h09, d0);
    chk(d0, 16'h0080);
    u_dpr_host_model.rd(8'h00, d0);
    chk(d0, 16'h0000);
    u_dpr_host_model.rd(8'h16, d0);
    chk(d0[3:0], 4'hA);
    u_dpr_host_model.rd(8'h30, d0);
    chk(d0, 16'h0000);
  endtask
  // three events pushed back to back, drained by two-word reads
  task t_events;
    logic [14:0] i;
    chk(evt_ready, 1'b1);
    evt_push = 1'b1;
    for (i = 1; i < 4; i++)
    begin
      evt_code = 15'h0100 + i;
      evt_param = 16'hA000 + i;
      @(negedge clk_sys);
    end
    evt_push = 1'b0;
    @(negedge clk_sys);
    chk(irq_pending, 1'b1);
    for (i = 1; i < 4; i++)
    begin
      u_dpr_host_model.rd2(8'h00, 8'h01, d0, d1);
      chk(d0, {1'b0, 15'h0100 + i});
      chk(d1, 16'hA000 + i);
    end
    u_dpr_host_model.rd(8'h00, d0);
    chk(d0, 16'h0000);
    chk(irq_pending, 1'b0);
  endtask
  // masked and unmasked fault transitions, parameter reread
  task t_system;
    u_dpr_host_model.wr(8'h0D, 16'h0002);
    chk(sys_mask_out, 16'h0002);
    sys_fault_in = 16'h0003;
    repeat (3) @(negedge clk_sys);
    u_dpr_host_model.rd2(8'h00, 8'h01, d0, d1);
    chk(d0, 16'h8001);
    chk(d1, 16'h0003);
    u_dpr_host_model.rd2(8'h01, 8'h00, d0, d1);
    chk(d0, 16'h0003);
    chk(d1, 16'h0003);
    u_dpr_host_model.rd(8'h00, d0);
    chk(d0, 16'h0000);
    u_dpr_host_model.wr(8'h0C, 16'hFFFF);
    u_dpr_host_model.rd(8'h0C, d0);
    chk(d0, 16'h0003);
  endtask
  // checksum pair and program launch
  task t_load;
    u_dpr_host_model.wr(8'h04, 16'h1234);
    u_dpr_host_model.wr(8'h05, 16'h5678);
    chk(checksum_out, 32'h12345678);
    u_dpr_host_model.rd(8'h05, d0);
    chk(d0, 16'h5678);
    u_dpr_host_model.launch(32'h00012345);
    chk(entry_addr_out, 32'h00012345);
  endtask
  // plain words reach their outputs, mailbox set sticks, busy clear
  task t_words;
    u_dpr_host_model.wr(8'h02, 16'h0155);
    chk(page_offset_out, 16'h0155);
    u_dpr_host_model.wr(8'h06, 16'h0012);
    chk(base_addr_out, 32'h0012FF00);
    u_dpr_host_model.wr(8'h0B, 16'h00C3);
    chk(mclk_cfg_out, 16'h00C3);
    u_dpr_host_model.wr(8'h03, 16'h0002);
    u_dpr_host_model.wr(8'h03, 16'h0000);
    chk(mbox_flag_out, 2'h2);
    u_dpr_host_model.rd(8'h07, d0);
    chk(d0, 16'hFF00);
  endtask
  // watchdog: the tests take well under a thousand cycles
  initial
  begin
    #100000;
    mismatches++;
    tally_and_finish;
  end
  // main sequence
  initial
  begin
    repeat (20) @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (2) @(negedge clk_sys);
    t_reset;
    t_events;
    t_system;
    t_load;
    t_words;
    tally_and_finish;
  end
endmodule
`default_nettype wire
